// *** rtl/ctm_cycle_timing.sv ***
// ctm_cycle_timing: card socket memory word cycle timing generator
// assumes one 125 MHz reference clock; card pins arrive asynchronously
// What this block does and what it expects of the card
// R1 - each phase lasts prescaler times multiplier plus one internal clocks
// R2 - enables, register select, address, write data valid setup factor before strobe
// R3 - command strobe stays asserted at least the command factor
// R4 - address and write data held recovery factor after strobe release
// R5 - select bit zero: internal clock runs seven fourths of input clock
// R6 - select bit one: internal clock equals the input clock
// R7 - timer set 0 resets to setup 1, command 6, recovery 3
// R8 - card asserts wait no later than command factor minus two clocks
// R9 - strobe extends during wait and holds two clocks after release
// R10 - card drives read data within one clock after releasing wait
// R11 - card holds read data two clocks before output enable release
// R12 - output enable strobes reads, write enable strobes writes, same phases
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`include "ctm_cfg.svh"

module ctm_cycle_timing (
  input wire logic ref_clk_in, // reference clock
  input wire logic srst_in, // synchronous reset, high
  input wire logic [7:0] reg_addr_in, // register index
  input wire logic [7:0] reg_wdata_in, // register write data
  input wire logic reg_wr_in, // register write strobe
  input wire logic reg_rd_in, // register read strobe
  output logic [7:0] reg_rdata_out, // read data, cycle after strobe
  input wire logic cyc_req_in, // start a card cycle, taken when idle
  input wire logic cyc_write_in, // 1 write, 0 read
  input wire logic cyc_attr_in, // 1 selects attribute space
  input wire logic [25:0] cyc_addr_in, // card address
  input wire logic [15:0] cyc_wdata_in, // write data
  output logic cyc_busy_out, // cycle in progress
  output logic cyc_done_out, // one-cycle pulse at cycle end
  output logic [15:0] cyc_rdata_out, // data captured on a read
  output logic [1:0] card_ce_n_out, // card enables, low
  output logic card_reg_n_out, // register select, low
  output logic [25:0] card_addr_out, // card address pins
  output logic [15:0] card_data_out, // data pins, driven value
  output logic card_data_oe_out, // data pins driven
  input wire logic [15:0] card_data_in, // data pins, sampled value
  output logic card_oe_n_out, // read strobe, low
  output logic card_we_n_out, // write strobe, low
  input wire logic card_wait_n_in // card wait, low stretches
);

  ctm_pkg::ctm_st_t st;
  ctm_pkg::ctm_st_t nx;

  // phase factor from one timing register
  function automatic logic [14:0] ctm_factor(input logic [7:0] v);
    logic [8:0] pres;
    logic [17:0] prod;
    case (v[`CTM_PRES_HI:`CTM_PRES_LO])
      2'b00: pres = `CTM_PRES_0;
      2'b01: pres = `CTM_PRES_1;
      2'b10: pres = `CTM_PRES_2;
      default: pres = `CTM_PRES_3;
    endcase
    // operands widened first so the largest prescaler does not wrap
    prod = {9'h000, pres} * {12'h000, v[`CTM_VAL_HI:`CTM_VAL_LO]} + 18'h00001; // R1
    return prod[14:0];
  endfunction

  logic [14:0] fac_s;
  logic [14:0] fac_c;
  logic [14:0] fac_r;
  logic [5:0] acc_sum;

  // factors of the selected set; latched set keeps a cycle self-consistent
  always_comb begin
    fac_s = ctm_factor(st.cset ? st.s1 : st.s0);
    fac_c = ctm_factor(st.cset ? st.c1 : st.c0);
    fac_r = ctm_factor(st.cset ? st.r1 : st.r0);
  end

  // internal clock as a tick from a fractional accumulator
  always_comb begin
    if (st.ctrl[`CTM_CTRL_BYPASS]) begin
      acc_sum = {1'b0, st.acc} + `CTM_STEP_BYP; // R6
    end else begin
      acc_sum = {1'b0, st.acc} + `CTM_STEP_SYN; // R5
    end
  end

  // next state of everything
  always_comb begin
    nx = st;
    // pin inputs: three flops, a change counts once stages two and three agree
    nx.w1 = card_wait_n_in;
    nx.w2 = st.w1;
    nx.w3 = st.w2;
    if (st.w2 == st.w3) begin
      nx.wait_n = st.w3;
    end
    nx.d1 = card_data_in;
    nx.d2 = st.d1;
    nx.d3 = st.d2;
    if (st.d2 == st.d3) begin
      nx.dfil = st.d3;
    end
    // tick generator
    if (acc_sum >= 6'(`CTM_ACC_MOD)) begin
      nx.acc = 5'(acc_sum - 6'(`CTM_ACC_MOD));
      nx.tick = 1'b1;
    end else begin
      nx.acc = acc_sum[4:0];
      nx.tick = 1'b0;
    end
    // register writes
    if (reg_wr_in) begin
      if (reg_addr_in == `CTM_OFS_SETUP0) begin
        nx.s0 = reg_wdata_in;
      end else if (reg_addr_in == `CTM_OFS_CMD0) begin
        nx.c0 = reg_wdata_in;
      end else if (reg_addr_in == `CTM_OFS_RECOV0) begin
        nx.r0 = reg_wdata_in;
      end else if (reg_addr_in == `CTM_OFS_SETUP1) begin
        nx.s1 = reg_wdata_in;
      end else if (reg_addr_in == `CTM_OFS_CMD1) begin
        nx.c1 = reg_wdata_in;
      end else if (reg_addr_in == `CTM_OFS_RECOV1) begin
        nx.r1 = reg_wdata_in;
      end else if (reg_addr_in == `CTM_OFS_CTRL) begin
        nx.ctrl = reg_wdata_in[1:0];
      end
    end
    // register reads; unmapped indexes read zero
    nx.rd = 8'h00;
    if (reg_rd_in) begin
      if (reg_addr_in == `CTM_OFS_SETUP0) begin
        nx.rd = st.s0;
      end else if (reg_addr_in == `CTM_OFS_CMD0) begin
        nx.rd = st.c0;
      end else if (reg_addr_in == `CTM_OFS_RECOV0) begin
        nx.rd = st.r0;
      end else if (reg_addr_in == `CTM_OFS_SETUP1) begin
        nx.rd = st.s1;
      end else if (reg_addr_in == `CTM_OFS_CMD1) begin
        nx.rd = st.c1;
      end else if (reg_addr_in == `CTM_OFS_RECOV1) begin
        nx.rd = st.r1;
      end else if (reg_addr_in == `CTM_OFS_CTRL) begin
        nx.rd = {6'h00, st.ctrl};
      end else if (reg_addr_in == `CTM_OFS_STAT) begin
        nx.rd = {3'h0, ~st.wait_n, st.busy, st.state};
      end
    end
    // cycle sequencer; counts only on internal clock ticks
    nx.done = 1'b0;
    case (st.state)
      ctm_pkg::CTM_IDLE: begin
        if (cyc_req_in) begin
          nx.cset = st.ctrl[`CTM_CTRL_SET];
          nx.cwr = cyc_write_in;
          nx.ce_n = 2'b00; // R2
          nx.reg_n = ~cyc_attr_in; // R2
          nx.addr = cyc_addr_in; // R2
          nx.dout = cyc_wdata_in; // R2
          nx.doe = cyc_write_in;
          // one extra tick: the request is not tick aligned, the first tick is partial
          nx.cnt = ctm_factor(st.ctrl[`CTM_CTRL_SET] ? st.s1 : st.s0) + 15'h0001; // R2
          nx.state = ctm_pkg::CTM_SETUP;
        end
      end
      ctm_pkg::CTM_SETUP: begin
        if (st.tick) begin
          if (st.cnt == 15'h0001) begin
            nx.oe_n = st.cwr; // R12
            nx.we_n = ~st.cwr; // R12
            nx.cnt = fac_c; // R3
            nx.hold = 2'h3; // no wait seen yet
            nx.state = ctm_pkg::CTM_CMD;
          end else begin
            nx.cnt = st.cnt - 15'h0001;
          end
        end
      end
      ctm_pkg::CTM_CMD: begin
        if (st.tick) begin
          // strobe ends only past the factor, out of wait, and after the hold
          if (st.cnt == 15'h0001 && st.wait_n && st.hold >= `CTM_WAIT_HOLD) begin // R3 R9
            nx.oe_n = 1'b1;
            nx.we_n = 1'b1;
            if (!st.cwr) begin
              nx.rdata = st.dfil; // card holds data up to here
            end
            nx.cnt = fac_r; // R4
            nx.state = ctm_pkg::CTM_RECOV;
          end else begin
            if (st.cnt != 15'h0001) begin
              nx.cnt = st.cnt - 15'h0001;
            end
            if (!st.wait_n) begin
              nx.hold = 2'h0; // R9
            end else if (st.hold != 2'h3) begin
              nx.hold = st.hold + 2'h1; // R9
            end
          end
        end
      end
      ctm_pkg::CTM_RECOV: begin
        // address and write data stay put through recovery
        if (st.tick) begin
          if (st.cnt == 15'h0001) begin
            nx.doe = 1'b0; // R4
            nx.ce_n = 2'b11;
            nx.done = 1'b1;
            nx.state = ctm_pkg::CTM_IDLE;
          end else begin
            nx.cnt = st.cnt - 15'h0001;
          end
        end
      end
      default: begin
        nx.state = ctm_pkg::CTM_IDLE;
      end
    endcase
    nx.busy = (nx.state != ctm_pkg::CTM_IDLE);
  end

  // single state register; reset leaves the socket quiet
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      st <= '0;
      st.s0 <= `CTM_RST_SETUP0; // R7
      st.c0 <= `CTM_RST_CMD0; // R7
      st.r0 <= `CTM_RST_RECOV0; // R7
      st.s1 <= `CTM_RST_SET1;
      st.c1 <= `CTM_RST_SET1;
      st.r1 <= `CTM_RST_SET1;
      st.w1 <= 1'b1;
      st.w2 <= 1'b1;
      st.w3 <= 1'b1;
      st.wait_n <= 1'b1;
      st.ce_n <= 2'b11;
      st.reg_n <= 1'b1;
      st.oe_n <= 1'b1;
      st.we_n <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  assign reg_rdata_out = st.rd;
  assign cyc_busy_out = st.busy;
  assign cyc_done_out = st.done;
  assign cyc_rdata_out = st.rdata;
  assign card_ce_n_out = st.ce_n;
  assign card_reg_n_out = st.reg_n;
  assign card_addr_out = st.addr;
  assign card_data_out = st.dout;
  assign card_data_oe_out = st.doe;
  assign card_oe_n_out = st.oe_n;
  assign card_we_n_out = st.we_n;

  // helper: ticks spent in the current phase
  logic [15:0] h_ticks;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in || nx.state != st.state) begin
      h_ticks <= 16'h0000;
    end else if (st.tick) begin
      h_ticks <= h_ticks + 16'h0001;
    end
  end

  default clocking ctm_cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  a_factor_calc: assert property ( // R1
    st.state == ctm_pkg::CTM_SETUP && st.cset == 1'b0 && st.s0[7:6] == 2'b00
      |-> fac_s == {9'h000, st.s0[5:0]} + 15'h0001)
    else $error("setup factor wrong");
  a_setup_len: assert property ( // R2
    st.state == ctm_pkg::CTM_SETUP && nx.state == ctm_pkg::CTM_CMD
      |-> h_ticks == {1'b0, fac_s} && card_ce_n_out == 2'b00)
    else $error("setup phase length wrong");
  a_cmd_len: assert property ( // R3
    st.state == ctm_pkg::CTM_CMD && nx.state == ctm_pkg::CTM_RECOV
      |-> h_ticks + 16'h0001 >= {1'b0, fac_c})
    else $error("command strobe too short");
  a_recov_hold: assert property ( // R4
    st.state == ctm_pkg::CTM_RECOV |=> $stable(card_addr_out) && $stable(card_data_out))
    else $error("address moved in recovery");
  a_synth_rate: assert property ( // R5
    st.tick && !st.ctrl[`CTM_CTRL_BYPASS] && $stable(st.ctrl)
      |=> (!st.tick [*3] ##1 st.tick) or (##[0:2] $changed(st.ctrl)))
    else $error("synthesized tick rate wrong");
  a_bypass_rate: assert property ( // R6
    st.tick && st.ctrl[`CTM_CTRL_BYPASS] && $stable(st.ctrl)
      |=> (!st.tick [*6] ##1 st.tick) or (##[0:5] $changed(st.ctrl)))
    else $error("bypass tick rate wrong");
  a_reset_vals: assert property (@(posedge ref_clk_in) disable iff (1'b0) // R7
    srst_in |=> st.s0 == `CTM_RST_SETUP0 && st.c0 == `CTM_RST_CMD0
      && st.r0 == `CTM_RST_RECOV0)
    else $error("timer set 0 reset value wrong");
  a_wait_hold: assert property ( // R9
    st.state == ctm_pkg::CTM_CMD && !st.wait_n |=> !(card_oe_n_out && card_we_n_out))
    else $error("strobe dropped during wait");
  a_strobe_kind: assert property ( // R12
    !card_oe_n_out |-> !st.cwr && card_we_n_out)
    else $error("read strobe on a write");

  c_read: cover property (st.state == ctm_pkg::CTM_RECOV && !st.cwr && cyc_done_out == 1'b0);
  c_write: cover property (cyc_done_out && st.cwr);
  c_stretch: cover property (st.state == ctm_pkg::CTM_CMD && !st.wait_n);

endmodule

// *** rtl/ctm_cfg.svh ***
// ctm_cfg.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the cycle timing block only
`ifndef CTM_CFG_SVH
`define CTM_CFG_SVH

// register offsets on the 8-bit index port
`define CTM_OFS_SETUP0 8'h3A
`define CTM_OFS_CMD0 8'h3B
`define CTM_OFS_RECOV0 8'h3C
`define CTM_OFS_SETUP1 8'h3D
`define CTM_OFS_CMD1 8'h3E
`define CTM_OFS_RECOV1 8'h3F
`define CTM_OFS_CTRL 8'h40
`define CTM_OFS_STAT 8'h41

// reset values of timer sets 0 and 1 (prescaler 1 in every phase)
`define CTM_RST_SETUP0 8'h01
`define CTM_RST_CMD0 8'h06
`define CTM_RST_RECOV0 8'h03
`define CTM_RST_SET1 8'h00

// timing register fields: prescaler select and multiplier value
`define CTM_PRES_HI 7
`define CTM_PRES_LO 6
`define CTM_VAL_HI 5
`define CTM_VAL_LO 0

// prescaler values selected by the two-bit field
`define CTM_PRES_0 9'h001
`define CTM_PRES_1 9'h010
`define CTM_PRES_2 9'h040
`define CTM_PRES_3 9'h100

// control register bits
`define CTM_CTRL_BYPASS 0
`define CTM_CTRL_SET 1

// reference clock and clock pin periods in ns; the pin clock is modelled
`define CTM_REF_NS 8
`define CTM_PIN_CLK_NS 56
`define CTM_PIN_CLK_DIV (`CTM_PIN_CLK_NS / `CTM_REF_NS)
// tick accumulator: modulus 4*div, step 7 with synthesizer, 4 bypassed
`define CTM_ACC_MOD (4 * `CTM_PIN_CLK_DIV)
`define CTM_STEP_SYN 6'h07
`define CTM_STEP_BYP 6'h04

// strobe hold after wait release, in internal clocks
`define CTM_WAIT_HOLD 2'h2

`endif

// *** rtl/ctm_pkg.sv ***
// ctm_pkg: types shared by the card cycle timing block
// assumes ctm_cfg.svh carries all numeric constants
package ctm_pkg;

  typedef enum logic [2:0] {
    CTM_IDLE = 3'b000,
    CTM_SETUP = 3'b001,
    CTM_CMD = 3'b010,
    CTM_RECOV = 3'b011
  } ctm_state_t;

  typedef struct packed {
    ctm_state_t state;
    logic [14:0] cnt;
    logic [1:0] hold;
    logic [4:0] acc;
    logic tick;
    logic [7:0] s0;
    logic [7:0] c0;
    logic [7:0] r0;
    logic [7:0] s1;
    logic [7:0] c1;
    logic [7:0] r1;
    logic [1:0] ctrl;
    logic cset;
    logic cwr;
    logic w1;
    logic w2;
    logic w3;
    logic wait_n;
    logic [15:0] d1;
    logic [15:0] d2;
    logic [15:0] d3;
    logic [15:0] dfil;
    logic [15:0] rdata;
    logic done;
    logic busy;
    logic [1:0] ce_n;
    logic reg_n;
    logic [25:0] addr;
    logic [15:0] dout;
    logic doe;
    logic oe_n;
    logic we_n;
    logic [7:0] rd;
  } ctm_st_t;

endpackage

// *** test/ctm_card_model.sv ***
// ctm_card_model: memory card in the socket, answers reads, stretches on request
// assumes low-active strobes from the timing block and one reference clock
`timescale 1ns/100ps

module ctm_card_model (
  input wire logic ref_clk_in, // reference clock
  input wire logic card_oe_n_in, // read strobe, low
  input wire logic card_we_n_in, // write strobe, low
  input wire logic [15:0] word_in, // word returned on reads
  input wire logic [11:0] wait_len_in, // stretch length in clocks, 0 none
  output logic [15:0] card_data_out, // data pins towards the block
  output logic card_wait_n_out // wait, low stretches
);
  logic [11:0] wcnt = 12'h000;
  logic strb_q = 1'b0;
  logic [15:0] noise = 16'h5A5A;

  // wait starts one clock after the strobe, well inside the allowed window
  always @(posedge ref_clk_in) begin
    strb_q <= ~(card_oe_n_in & card_we_n_in);
    noise <= ~noise;
    if (card_oe_n_in & card_we_n_in) begin
      wcnt <= 12'h000;
    end else if (!strb_q) begin
      wcnt <= wait_len_in;
    end else if (wcnt != 12'h000) begin
      wcnt <= wcnt - 12'h001;
    end
  end

  assign card_wait_n_out = (wcnt == 12'h000);
  // valid while the read strobe is low and wait is not; toggling noise otherwise, no hold owed
  assign card_data_out = (!card_oe_n_in && wcnt == 12'h000) ? word_in : noise;
endmodule

// *** test/ctm_cycle_timing_tb.sv ***
// ctm_cycle_timing_tb: random and corner card cycles checked against phase timing
// assumes the design and the card model are compiled before this file
`timescale 1ns/100ps

module ctm_cycle_timing_tb;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic cyc_req_in = 1'b0, cyc_write_in = 1'b0, cyc_attr_in = 1'b0;
  logic [25:0] cyc_addr_in = 26'h0000000, card_addr_out;
  logic [15:0] cyc_wdata_in = 16'h0000, cyc_rdata_out, card_data_out, card_data_in;
  logic [15:0] word = 16'h0000;
  logic cyc_busy_out, cyc_done_out, card_reg_n_out, card_data_oe_out;
  logic card_oe_n_out, card_we_n_out, card_wait_n_in;
  logic [1:0] card_ce_n_out;
  logic [11:0] wait_len = 12'h000;
  logic [31:0] seed = 32'h97D9B673;
  logic [7:0] rst_tab [6] = '{8'h01, 8'h06, 8'h03, 8'h00, 8'h00, 8'h00};
  int fail_count = 0;
  int check_count = 0;

  ctm_cycle_timing ctm_cycle_timing_i (.ref_clk_in, .srst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cyc_req_in, .cyc_write_in, .cyc_attr_in,
    .cyc_addr_in, .cyc_wdata_in, .cyc_busy_out, .cyc_done_out, .cyc_rdata_out,
    .card_ce_n_out, .card_reg_n_out, .card_addr_out, .card_data_out, .card_data_oe_out,
    .card_data_in, .card_oe_n_out, .card_we_n_out, .card_wait_n_in);
  ctm_card_model ctm_card_model_i (.ref_clk_in, .card_oe_n_in(card_oe_n_out),
    .card_we_n_in(card_we_n_out), .word_in(word), .wait_len_in(wait_len),
    .card_data_out(card_data_in), .card_wait_n_out(card_wait_n_in));

  always #4 ref_clk_in = ~ref_clk_in;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // phase length in internal clocks from one timing register
  function automatic int fac(input logic [7:0] v);
    return (v[7:6] == 2'h0 ? 1 : v[7:6] == 2'h1 ? 16 : v[7:6] == 2'h2 ? 64 : 256) * v[5:0] + 1;
  endfunction

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe, so sample just after that edge
  task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1 check("reg_rdata_out", {24'h0, reg_rdata_out}, {24'h0, exp});
  endtask

  // one card cycle; counts reference clocks spent in setup, command and recovery
  task automatic run_cyc(input logic wr, input logic at, input int s, input int c,
      input int r, input int p);
    int ns = 0;
    int nc = 0;
    int nr = 0;
    int nh = 0;
    int i;
    logic bad = 1'b0;
    logic seenw = 1'b0;
    @(posedge ref_clk_in);
    cyc_req_in <= 1'b1;
    cyc_write_in <= wr;
    cyc_attr_in <= at;
    cyc_addr_in <= seed[25:0];
    cyc_wdata_in <= seed[31:16];
    word <= ~seed[15:0];
    @(posedge ref_clk_in);
    cyc_req_in <= 1'b0;
    for (i = 0; i < 20000; i++) begin
      @(negedge ref_clk_in);
      if (cyc_done_out === 1'b1) break;
      bad |= (card_ce_n_out !== 2'b00) | (card_addr_out !== cyc_addr_in)
        | (card_reg_n_out !== ~at) | (cyc_busy_out !== 1'b1) | (card_data_oe_out !== wr)
        | ((wr ? card_oe_n_out : card_we_n_out) !== 1'b1)
        | (wr && card_data_out !== cyc_wdata_in);
      if ((wr ? card_we_n_out : card_oe_n_out) === 1'b0) begin
        nc++;
        if (card_wait_n_in === 1'b0) seenw = 1'b1;
        else if (seenw) nh++;
      end else if (nc == 0) begin
        ns++;
      end else begin
        nr++;
      end
    end
    if (i == 20000) begin
      check("cyc_done_out", 0, 1);
      tally_and_finish();
    end
    check("pins held during cycle", bad, 0);
    check("setup clocks", ns >= s * p - 1 && ns <= (s + 1) * p + 2, 1);
    check("command clocks", nc >= c * p - 1 && (seenw || nc <= c * p + 1), 1);
    check("recovery clocks", nr >= r * p - 1 && nr <= (r + 1) * p + 2, 1);
    check("strobe hold after wait", !seenw || nh >= 2 * p, 1);
    if (!wr) check("cyc_rdata_out", cyc_rdata_out, word);
  endtask

  initial begin
    repeat (12) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    // reset values, an unmapped index and the read-only status
    for (int k = 0; k < 6; k++) reg_chk(8'h3A + k[7:0], rst_tab[k]);
    reg_chk(8'h55, 8'h00);
    reg_wr(8'h41, 8'hFF);
    reg_chk(8'h41, 8'h00);
    run_cyc(1'b0, 1'b0, 2, 7, 4, 4);
    for (int n = 0; n < 14; n++) begin
      logic [7:0] tv [3];
      logic st;
      logic byp;
      seed = lfsr(seed);
      st = seed[9];
      byp = seed[10];
      // first pass uses the smallest factors; one pass uses the 16 prescaler
      for (int k = 0; k < 3; k++) begin
        seed = lfsr(seed);
        tv[k] = n == 0 ? 8'h00 : {1'b0, seed[4] & (n == 3), 3'h0, seed[2:0]};
        reg_wr((st ? 8'h3D : 8'h3A) + k[7:0], tv[k]);
        reg_chk((st ? 8'h3D : 8'h3A) + k[7:0], tv[k]);
      end
      reg_wr(8'h40, {seed[31:26], st, byp});
      reg_chk(8'h40, {6'h00, st, byp});
      wait_len <= fac(tv[1]) >= 4 ? {4'h0, seed[23:16]} + 12'h001 : 12'h000;
      // a one-clock strobe leaves the card no room for its data setup, so write then
      run_cyc(n == 1 || seed[11] || fac(tv[1]) < 2, seed[12], fac(tv[0]), fac(tv[1]), fac(tv[2]),
        byp ? 7 : 4);
      reg_chk(8'h41, 8'h00);
    end
    tally_and_finish();
  end
endmodule
